// ==== src/lpac_cfg.svh ====
// Constants of the receiver phase alignment block: register offsets, reset values and counts.
// Assumes a 32-bit Avalon-MM slave with byte addresses and a 25 MHz system clock.
`ifndef LPAC_CFG_SVH
`define LPAC_CFG_SVH
`define LPAC_ADDR_CTRL      5'h00
`define LPAC_ADDR_STATUS    5'h04
`define LPAC_ADDR_IRQ_STAT  5'h08
`define LPAC_ADDR_IRQ_MASK  5'h0C
`define LPAC_ADDR_DATA      5'h10
`define LPAC_CTRL_RST       8'h18
`define LPAC_IRQ_RST        2'h0
`define LPAC_DESER          4'hA
`define LPAC_DIV_HALF       4'h5
`define LPAC_TRANS_TARGET   9'h100
`define LPAC_PLL_STEP       3'h2
`define LPAC_DLY_STEP       3'h1
`define LPAC_HALF_TAPS      3'h4
`define LPAC_IRQ_LOCK       0
`define LPAC_IRQ_PHASE      1
`endif

// ==== src/lpac_pkg.sv ====
// Types of the receiver phase alignment block.
// Assumes lpac_cfg.svh for every numeric constant.
package lpac_pkg;
   typedef enum logic [1:0] {LPAC_M_DPA, LPAC_M_STATIC, LPAC_M_CDR} lpac_mode_t;
   typedef enum logic [2:0] {CAL_IDLE, CAL_STEP1, CAL_STEP2, CAL_STEP3, CAL_LOCKED} lpac_cal_t;
   typedef struct packed {
      logic [2:0] static_phase;
      logic       std_out;
      logic       clear;
      logic       pll_cal;
      logic [1:0] mode;
   } lpac_ctrl_t;
   typedef struct packed {
      logic        read;
      logic        write;
      logic [4:0]  addr;
      logic [31:0] wdata;
      logic        lane0;
   } lpac_avs_req_t;
endpackage

// ==== src/lpac_trans_cnt.sv ====
// Transition counter used by the calibration sequence.
// Assumes bit_in is already synchronous to clk_sys.
`timescale 1ns/100ps
`include "lpac_cfg.svh"
module lpac_trans_cnt (
   input  wire logic       clk_sys,
   input  wire logic       resetn,
   input  wire logic       restart,
   input  wire logic       bit_in,
   output logic [8:0]      count_q
);
   logic       prev_q;
   logic [8:0] count_d;

   always_comb begin
      count_d = count_q;
      if (restart) begin
         count_d = 9'h000;
      end else if (bit_in != prev_q && count_q != `LPAC_TRANS_TARGET) begin
         count_d = 9'(count_q + 9'h001);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         count_q <= 9'h000;
         prev_q  <= 1'b0;
      end else begin
         count_q <= count_d;
         prev_q  <= bit_in;
      end
   end
endmodule

// ==== src/lpac_rx_align.sv ====
// Receiver phase alignment, calibration and deserializer for one channel, with Avalon-MM registers.
// Assumes rx_taps are eight phase-spaced samples of the serial line from outside the clock domain.
`timescale 1ns/100ps
`include "lpac_cfg.svh"
module lpac_rx_align
   import lpac_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   output logic             irq,
   input  wire logic [7:0]  rx_taps,
   output logic [9:0]       rx_word,
   output logic             rx_word_valid,
   output logic             rx_divfwd_clk,
   output logic             rx_par_clk,
   output logic             dpa_locked,
   output logic             pll_shift_fwd,
   output logic             pll_shift_back,
   output logic             pll_quarter_pull,
   output logic             dly_insert
);
   function automatic logic [2:0] tap_add(input logic [2:0] a, input logic [2:0] b);
      tap_add = 3'(a + b);
   endfunction

   lpac_avs_req_t req;
   lpac_ctrl_t    ctrl_q, ctrl_d;
   lpac_mode_t    mode;
   lpac_cal_t     cal_q, cal_d;
   logic [1:0]    irq_stat_q, irq_stat_d, irq_mask_q, irq_mask_d, irq_set;
   logic [31:0]   rdata_d;
   logic          wait_d, irq_d, hit;
   logic [7:0]    tap_m_q, tap_s_q;
   logic [2:0]    phase_q, phase_d, ofs, samp_tap, ideal;
   logic          edge_found, bit_s, cnt_restart;
   logic [8:0]    trans_cnt;
   logic [3:0]    bit_cnt_q, bit_cnt_d, pcnt_q, pcnt_d;
   logic [9:0]    shift_q, shift_d, word_q, word_d, cap1_q, cap1_d, out_q, out_d;
   logic          stb_q, stb_d, cap1_v_q, cap1_v_d, out_v_d;
   logic          div_d, pclk_d;
   logic          lock_q, lock_d, fwd_d, back_d, pull_d, dly_d;

   assign req = '{read: avs_read, write: avs_write, addr: avs_address, wdata: avs_writedata,
                  lane0: avs_byteenable[0]};

   always_comb begin
      case (ctrl_q.mode)
         2'h0:    mode = LPAC_M_DPA;
         2'h2:    mode = LPAC_M_CDR;
         default: mode = LPAC_M_STATIC;
      endcase
   end

   // Register group. One wait cycle keeps read data registered and the decode off the bus path.
   always_comb begin
      ctrl_d     = ctrl_q;
      irq_mask_d = irq_mask_q;
      rdata_d    = avs_readdata;
      wait_d     = !((req.read || req.write) && avs_waitrequest);
      irq_set    = 2'h0;
      irq_set[`LPAC_IRQ_LOCK]  = lock_d && !lock_q;
      irq_set[`LPAC_IRQ_PHASE] = lock_q && (phase_d != phase_q);
      irq_stat_d = irq_stat_q;
      if (req.read && avs_waitrequest) begin
         if (req.addr == `LPAC_ADDR_CTRL) begin
            rdata_d = {24'h000000, ctrl_q};
         end else if (req.addr == `LPAC_ADDR_STATUS) begin
            rdata_d = {23'h000000, phase_q, cal_q, lock_q, mode};
         end else if (req.addr == `LPAC_ADDR_IRQ_STAT) begin
            rdata_d = {30'h00000000, irq_stat_q};
         end else if (req.addr == `LPAC_ADDR_IRQ_MASK) begin
            rdata_d = {30'h00000000, irq_mask_q};
         end else if (req.addr == `LPAC_ADDR_DATA) begin
            rdata_d = {22'h000000, out_q};
         end else begin
            rdata_d = 32'h00000000;
         end
      end
      if (req.write && !avs_waitrequest && req.lane0) begin
         if (req.addr == `LPAC_ADDR_CTRL) begin
            ctrl_d = lpac_ctrl_t'(req.wdata[7:0]);
         end else if (req.addr == `LPAC_ADDR_IRQ_STAT) begin
            irq_stat_d = irq_stat_q & ~req.wdata[1:0];
         end else if (req.addr == `LPAC_ADDR_IRQ_MASK) begin
            irq_mask_d = req.wdata[1:0];
         end
      end
      // A new event wins over a clear written in the same cycle.
      irq_stat_d = irq_stat_d | irq_set;
      irq_d      = |(irq_stat_d & irq_mask_d);
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         ctrl_q          <= lpac_ctrl_t'(`LPAC_CTRL_RST);
         irq_stat_q      <= `LPAC_IRQ_RST;
         irq_mask_q      <= `LPAC_IRQ_RST;
         avs_readdata    <= 32'h00000000;
         avs_waitrequest <= 1'b1;
         irq             <= 1'b0;
      end else begin
         ctrl_q          <= ctrl_d;
         irq_stat_q      <= irq_stat_d;
         irq_mask_q      <= irq_mask_d;
         avs_readdata    <= rdata_d;
         avs_waitrequest <= wait_d;
         irq             <= irq_d;
      end
   end

   // Tap synchroniser. Only the second stage is read by the logic.
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         tap_m_q <= 8'h00;
         tap_s_q <= 8'h00;
      end else begin
         tap_m_q <= rx_taps;
         tap_s_q <= tap_m_q;
      end
   end

   // Phase search: sample half a bit away from the first edge seen between adjacent taps.
   always_comb begin
      edge_found = 1'b0;
      ideal      = phase_q;
      for (int i = 0; i < 7; i++) begin
         if (!edge_found && tap_s_q[i] != tap_s_q[i+1]) begin
            edge_found = 1'b1;
            ideal      = tap_add(3'(i), `LPAC_HALF_TAPS);
         end
      end
      phase_d = phase_q;
      if (mode == LPAC_M_STATIC) begin
         phase_d = ctrl_q.static_phase;
      end else if (ctrl_q.clear) begin
         phase_d = phase_q;
      end else if (edge_found && (mode == LPAC_M_CDR || !lock_q)) begin
         // Dynamic mode freezes after lock to keep margin; recovery mode must follow ppm drift.
         phase_d = ideal;
      end
      ofs = 3'h0;
      if (cal_q == CAL_STEP2) begin
         ofs = ctrl_q.pll_cal ? `LPAC_PLL_STEP : `LPAC_DLY_STEP;
      end
      samp_tap = tap_add(phase_q, ofs);
      bit_s    = tap_s_q[samp_tap];
   end

   // Calibration group.
   always_comb begin
      cal_d       = cal_q;
      cnt_restart = 1'b0;
      hit         = (trans_cnt == `LPAC_TRANS_TARGET);
      if (ctrl_q.clear || mode == LPAC_M_STATIC) begin
         cal_d       = CAL_IDLE;
         cnt_restart = 1'b1;
      end else begin
         case (cal_q)
            CAL_IDLE:  cal_d = CAL_STEP1;
            CAL_STEP1: cal_d = hit ? CAL_STEP2 : CAL_STEP1;
            CAL_STEP2: cal_d = hit ? CAL_STEP3 : CAL_STEP2;
            CAL_STEP3: cal_d = hit ? CAL_LOCKED : CAL_STEP3;
            default:   cal_d = CAL_LOCKED;
         endcase
         cnt_restart = (cal_d != cal_q);
      end
      lock_d = (cal_d == CAL_LOCKED);
      fwd_d  = ctrl_q.pll_cal && cal_q == CAL_STEP1 && cal_d == CAL_STEP2;
      back_d = ctrl_q.pll_cal && cal_q == CAL_STEP2 && cal_d == CAL_STEP3;
      pull_d = ctrl_q.pll_cal && (cal_d == CAL_STEP1 || cal_d == CAL_STEP2 || cal_d == CAL_STEP3);
      dly_d  = !ctrl_q.pll_cal && cal_d == CAL_STEP2;
   end

   lpac_trans_cnt u_trans_cnt (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .restart (cnt_restart),
      .bit_in  (bit_s),
      .count_q (trans_cnt)
   );

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         cal_q          <= CAL_IDLE;
         phase_q        <= 3'h0;
         dpa_locked     <= 1'b0;
         lock_q         <= 1'b0;
         pll_shift_fwd  <= 1'b0;
         pll_shift_back <= 1'b0;
         pll_quarter_pull <= 1'b0;
         dly_insert     <= 1'b0;
      end else begin
         cal_q          <= cal_d;
         phase_q        <= phase_d;
         dpa_locked     <= lock_d;
         lock_q         <= lock_d;
         pll_shift_fwd  <= fwd_d;
         pll_shift_back <= back_d;
         pll_quarter_pull <= pull_d;
         dly_insert     <= dly_d;
      end
   end
   // Deserializer, capture stages and clock outputs.
   always_comb begin
      shift_d   = {shift_q[8:0], bit_s};
      bit_cnt_d = (bit_cnt_q == 4'(`LPAC_DESER - 4'h1)) ? 4'h0 : 4'(bit_cnt_q + 4'h1);
      pcnt_d    = (pcnt_q == 4'(`LPAC_DESER - 4'h1)) ? 4'h0 : 4'(pcnt_q + 4'h1);
      stb_d     = (bit_cnt_q == 4'(`LPAC_DESER - 4'h1));
      word_d    = stb_d ? shift_d : word_q;
      cap1_d    = word_q;
      cap1_v_d  = stb_q;
      out_d     = ctrl_q.std_out ? cap1_q : word_d;
      out_v_d   = ctrl_q.std_out ? cap1_v_q : stb_d;
      div_d     = (mode == LPAC_M_CDR) && (bit_cnt_d < `LPAC_DIV_HALF);
      pclk_d    = pcnt_d < `LPAC_DIV_HALF;
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         shift_q       <= 10'h000;
         bit_cnt_q     <= 4'h0;
         pcnt_q        <= 4'h0;
         stb_q         <= 1'b0;
         word_q        <= 10'h000;
         cap1_q        <= 10'h000;
         cap1_v_q      <= 1'b0;
         rx_word       <= 10'h000;
         rx_word_valid <= 1'b0;
         rx_divfwd_clk <= 1'b0;
         rx_par_clk    <= 1'b0;
      end else begin
         shift_q       <= shift_d;
         bit_cnt_q     <= bit_cnt_d;
         pcnt_q        <= pcnt_d;
         stb_q         <= stb_d;
         word_q        <= word_d;
         cap1_q        <= cap1_d;
         cap1_v_q      <= cap1_v_d;
         rx_word       <= out_d;
         rx_word_valid <= out_v_d;
         rx_divfwd_clk <= div_d;
         rx_par_clk    <= pclk_d;
      end
   end
   assign out_q   = rx_word;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   sequence s_bus_ack;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   sequence s_step_move(lpac_cal_t from, lpac_cal_t to);
      cal_q == from && hit ##1 cal_q == to && trans_cnt == 9'h000;
   endsequence

   a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> s_bus_ack)
      else $error("bus answer not a single cycle");
   a_static_no_cal: assert property (mode == LPAC_M_STATIC |=> cal_q == CAL_IDLE && !dpa_locked)
      else $error("calibration ran in static mode");
   a_static_phase_hold: assert property (mode == LPAC_M_STATIC |=> phase_q == $past(ctrl_q.static_phase))
      else $error("static phase not applied");
   a_step_one_two: assert property (!ctrl_q.clear && mode != LPAC_M_STATIC && cal_q == CAL_STEP1 && hit
      |-> s_step_move(CAL_STEP1, CAL_STEP2))
      else $error("step one did not advance at target count");
   a_lock_after_third: assert property (!ctrl_q.clear && mode != LPAC_M_STATIC && cal_q == CAL_STEP3 && hit
      |=> dpa_locked)
      else $error("lock not raised after third count");
   a_pll_shift_pair: assert property (pll_shift_fwd |-> $past(ctrl_q.pll_cal) && !dly_insert ##1 !pll_shift_fwd)
      else $error("PLL shift pulse with delay method");
   a_dly_only_step2: assert property (dly_insert |-> !ctrl_q.pll_cal && cal_q == CAL_STEP2 && !pll_quarter_pull)
      else $error("delay inserted outside step two");
   a_clear_restarts: assert property (ctrl_q.clear |=> cal_q == CAL_IDLE && trans_cnt == 9'h000 && !dpa_locked)
      else $error("clear did not restart calibration");
   a_divclk_cdr_only: assert property (mode != LPAC_M_CDR |=> !rx_divfwd_clk)
      else $error("divided clock outside recovery mode");
   a_std_two_stages: assert property (ctrl_q.std_out && stb_q && $stable(ctrl_q) ##1 $stable(ctrl_q)
      |=> rx_word_valid && rx_word == $past(word_q, 2))
      else $error("standard output not two stages after deserializer");
   a_irq_level: assert property (|(irq_stat_q & irq_mask_q) |-> irq)
      else $error("interrupt low with unmasked status set");
endmodule

// ==== test/lpac_tx_model.sv ====
// Serial transmitter model that feeds eight phase-spaced taps of one receive lane.
// Assumes one serial bit per clk_sys and a fixed skew between the data edge and the taps.
`timescale 1ns/100ps
module lpac_tx_model #(
   parameter int SKEW = 3
) (
   input  wire logic       clk_sys,
   input  wire logic       toggle_en,
   output logic [7:0]      rx_taps
);
   logic bit_q;
   initial begin
      bit_q = 1'b0;
      rx_taps = 8'h00;
   end
   // Taps below the skew still see the old bit, so the edge sits inside the bit as on a skewed lane.
   always @(posedge clk_sys) begin
      bit_q <= bit_q ^ toggle_en;
      for (int i = 0; i < 8; i++)
         rx_taps[i] <= (i < SKEW) ? bit_q : bit_q ^ toggle_en;
   end
endmodule

// ==== test/testbench.sv ====
// Self-checking bench for the receiver phase alignment block.
// Assumes the transmitter model in lpac_tx_model.sv and the register map of lpac_cfg.svh.
`timescale 1ns/100ps
`include "lpac_cfg.svh"
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin num_errors++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module testbench;
   logic        clk_sys;
   logic        resetn;
   logic [4:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        irq;
   logic [7:0]  rx_taps;
   logic [9:0]  rx_word;
   logic        rx_word_valid;
   logic        rx_divfwd_clk;
   logic        rx_par_clk;
   logic        dpa_locked;
   logic        pll_shift_fwd;
   logic        pll_shift_back;
   logic        pll_quarter_pull;
   logic        dly_insert;
   logic        toggle_en;
   logic        div_p;
   logic        par_p;
   logic [9:0]  user_f;
   logic [9:0]  user_r;
   logic [31:0] v;
   int          num_errors;
   int          total_checks;
   int          cyc;
   int          last_v;
   int          fwd_n;
   int          back_n;
   int          fwd_at;
   int          back_at;
   int          dly_n;
   int          qp_n;
   int          div_r;
   int          par_r;

   lpac_rx_align u_dut (.clk_sys(clk_sys), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .irq(irq), .rx_taps(rx_taps), .rx_word(rx_word),
      .rx_word_valid(rx_word_valid), .rx_divfwd_clk(rx_divfwd_clk), .rx_par_clk(rx_par_clk),
      .dpa_locked(dpa_locked), .pll_shift_fwd(pll_shift_fwd), .pll_shift_back(pll_shift_back),
      .pll_quarter_pull(pll_quarter_pull), .dly_insert(dly_insert));
   lpac_tx_model u_tx (.clk_sys(clk_sys), .toggle_en(toggle_en), .rx_taps(rx_taps));

   task automatic print_verdict();
      $display("Checks %0d, errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // The request is held until waitrequest is sampled low; only then is data taken and the request dropped.
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd, output logic [31:0] rd);
      int n;
      @(posedge clk_sys);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= wd;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 40);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 40) begin
         num_errors++;
         print_verdict();
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask

   task automatic rd(input logic [4:0] a);
      bus(1'b0, a, 32'h0, v);
   endtask

   task automatic zero();
      fwd_n = 0;
      back_n = 0;
      dly_n = 0;
      qp_n = 0;
      div_r = 0;
      par_r = 0;
   endtask

   task automatic wait_lock();
      int n;
      n = 0;
      while (dpa_locked !== 1'b1 && n < 3000) begin
         @(posedge clk_sys);
         n++;
      end
      if (n >= 3000) begin
         num_errors++;
         print_verdict();
      end
   endtask

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   // Outputs are watched on the falling edge, where they have settled and the stimulus cannot race them.
   always @(negedge clk_sys) begin
      cyc++;
      div_p <= rx_divfwd_clk;
      par_p <= rx_par_clk;
      if (rx_divfwd_clk === 1'b1 && div_p === 1'b0) div_r++;
      if (rx_par_clk === 1'b1 && par_p === 1'b0) par_r++;
      if (dly_insert === 1'b1) dly_n++;
      if (pll_quarter_pull === 1'b1) qp_n++;
      if (pll_shift_fwd === 1'b1) begin
         fwd_n++;
         fwd_at = cyc;
      end
      if (pll_shift_back === 1'b1) begin
         back_n++;
         back_at = cyc;
      end
      if (rx_word_valid === 1'b1 && resetn === 1'b1) begin
         if (last_v > 0) `CHK(cyc - last_v, 10)
         last_v = cyc;
      end
   end

   // The user's capture stages for unregistered output: falling edge first, rising edge second.
   always @(negedge rx_divfwd_clk) user_f <= rx_word;
   always @(posedge rx_divfwd_clk) user_r <= user_f;

   initial begin
      repeat (100000) @(posedge clk_sys);
      num_errors++;
      print_verdict();
   end

   initial begin
      {num_errors, total_checks, cyc, last_v, fwd_at, back_at} = '0;
      zero();
      resetn = 1'b0;
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      toggle_en = 1'b1;
      repeat (8) @(posedge clk_sys);
      resetn <= 1'b1;
      rd(`LPAC_ADDR_CTRL); `CHK(v, 32'h18)
      rd(`LPAC_ADDR_IRQ_STAT); `CHK(v, 32'h0)
      wr(5'h14, 32'hFF);
      rd(5'h14); `CHK(v, 32'h0)
      wr(`LPAC_ADDR_IRQ_MASK, 32'h1);
      rd(`LPAC_ADDR_IRQ_MASK); `CHK(v, 32'h1)
      // Static phase: no search, no calibration, no lock.
      zero();
      wr(`LPAC_ADDR_CTRL, 32'h31);
      repeat (900) @(posedge clk_sys);
      `CHK(dpa_locked, 1'b0)
      `CHK(qp_n + dly_n + fwd_n, 0)
      rd(`LPAC_ADDR_STATUS); `CHK(v[1:0], 2'h1)
      `CHK(v[8:6], 3'h1)
      // Dynamic mode with delay-element calibration.
      wr(`LPAC_ADDR_CTRL, 32'h18);
      zero();
      wr(`LPAC_ADDR_CTRL, 32'h10);
      wait_lock();
      `CHK(dly_n inside {[256:258]}, 1'b1)
      `CHK(fwd_n + back_n + qp_n, 0)
      repeat (3) @(posedge clk_sys);
      `CHK(irq, 1'b1)
      rd(`LPAC_ADDR_STATUS); `CHK(v[5:0], 6'h24)
      `CHK(rx_word === 10'h2AA || rx_word === 10'h155, 1'b1)
      rd(`LPAC_ADDR_DATA); `CHK(v[9:0] === 10'h2AA || v[9:0] === 10'h155, 1'b1)
      rd(`LPAC_ADDR_IRQ_STAT); `CHK(v[0], 1'b1)
      wr(`LPAC_ADDR_IRQ_STAT, 32'h3);
      rd(`LPAC_ADDR_IRQ_STAT); `CHK(v[1:0], 2'h0)
      `CHK(irq, 1'b0)
      zero();
      repeat (100) @(posedge clk_sys);
      `CHK(div_r, 0)
      `CHK(par_r, 10)
      wr(`LPAC_ADDR_CTRL, 32'h18);
      repeat (3) @(posedge clk_sys);
      `CHK(dpa_locked, 1'b0)
      // Recovery mode with PLL-shift calibration; a quiet line must not advance it.
      wr(`LPAC_ADDR_IRQ_MASK, 32'h0);
      toggle_en <= 1'b0;
      zero();
      wr(`LPAC_ADDR_CTRL, 32'h16);
      repeat (900) @(posedge clk_sys);
      `CHK(dpa_locked | pll_shift_fwd, 1'b0)
      `CHK(fwd_n, 0)
      `CHK(qp_n > 850, 1'b1)
      toggle_en <= 1'b1;
      wait_lock();
      `CHK(fwd_n * 16 + back_n, 17)
      `CHK((back_at - fwd_at) inside {[256:258]}, 1'b1)
      `CHK(dly_n, 0)
      repeat (3) @(posedge clk_sys);
      `CHK(pll_quarter_pull, 1'b0)
      `CHK(irq, 1'b0)
      rd(`LPAC_ADDR_IRQ_STAT); `CHK(v[0], 1'b1)
      rd(`LPAC_ADDR_STATUS); `CHK(v[2:0], 3'h6)
      zero();
      repeat (100) @(posedge clk_sys);
      `CHK(div_r, 10)
      `CHK(par_r, 10)
      // Unregistered output; the word spacing restarts once the output timing has moved.
      wr(`LPAC_ADDR_CTRL, 32'h06);
      @(posedge clk_sys);
      last_v = 0;
      repeat (40) @(posedge clk_sys);
      `CHK(user_r === 10'h2AA || user_r === 10'h155, 1'b1)
      `CHK(dpa_locked, 1'b1)
      // Clear stays low after lock here, since tracking must not be disturbed.
      print_verdict();
   end
endmodule
